/* File: core/serial_port.sv */
// Serial host port: three-wire and two-wire framing, shifting and pin direction
`timescale 1ns/1ns
module serial_port
    import serial_port_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     reset_n,
    input  wire logic     sclk,               // Host serial clock, sampled
    input  wire logic     frame_n,            // Frame-sync, active low
    input  wire logic     din_in,             // Data-in pin level (shared pin in two-wire)
    output logic          din_out,
    output logic          din_oe,
    output logic          dout_out,
    output logic          dout_oe,
    input  wire logic     conversion_start_n, // Hardware conversion start pin
    input  wire word_t    tx_word,            // Word to send in the next frame
    input  wire logic     cal_read,           // Calibration read sequence active
    input  wire logic     cal_write,          // Calibration write sequence active
    output logic          rx_valid,
    input  wire logic     rx_ready,
    output rx_word_s      rx_word,
    output logic          tx_taken,           // Pulse when tx_word is loaded
    output logic          two_wire,
    output logic          conv_start          // One-cycle start request
);
    // ***********************************************************
    // Input synchronisers
    // ***********************************************************
    logic [2:0] sclk_s;
    logic [2:0] frame_s;
    logic [2:0] din_s;
    logic [2:0] conv_s;
    logic       sclk_lvl;
    logic       frame_lvl;
    logic       din_lvl;
    logic       conv_lvl;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_s  <= 3'h7;
            frame_s <= 3'h7;
            din_s   <= 3'h0;
            conv_s  <= 3'h7;
        end
        else
        begin
            sclk_s  <= {sclk_s[1:0], sclk};
            frame_s <= {frame_s[1:0], frame_n};
            din_s   <= {din_s[1:0], din_in};
            conv_s  <= {conv_s[1:0], conversion_start_n};
        end
    end

    // Filtered levels, updated only when the late stages agree
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_lvl  <= 1'b1;
            frame_lvl <= 1'b1;
            din_lvl   <= 1'b0;
            conv_lvl  <= 1'b1;
        end
        else
        begin
            if (sclk_s[1] == sclk_s[2])   sclk_lvl  <= sclk_s[2];
            if (frame_s[1] == frame_s[2]) frame_lvl <= frame_s[2];
            if (din_s[1] == din_s[2])     din_lvl   <= din_s[2];
            if (conv_s[1] == conv_s[2])   conv_lvl  <= conv_s[2];
        end
    end

    logic next_sclk;
    logic next_frame;
    logic next_conv;
    assign next_sclk  = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_lvl;
    assign next_frame = (frame_s[1] == frame_s[2]) ? frame_s[2] : frame_lvl;
    assign next_conv  = (conv_s[1] == conv_s[2]) ? conv_s[2] : conv_lvl;

    logic active;
    logic rise;
    logic fall;
    logic frame_fall;
    logic frame_rise;
    assign active     = !next_frame;
    assign rise       = active && !frame_lvl && next_sclk && !sclk_lvl;
    assign fall       = active && !frame_lvl && !next_sclk && sclk_lvl;
    assign frame_fall = frame_lvl && !next_frame;
    assign frame_rise = !frame_lvl && next_frame;

    // ***********************************************************
    // Shift registers
    // ***********************************************************
    word_t      shift_in;
    word_t      shift_out;
    logic [4:0] rise_count;
    logic       word_done;
    logic       buf_ready;
    // A stalled buffer holds the count, so a word never ends without being stored
    assign word_done = rise && buf_ready && (rise_count == BIT_COUNT_FULL - 5'h1);

    // Capture on rising edges; frame-sync high clears the frame
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shift_in   <= WORD_ZERO;
            rise_count <= 5'h0;
        end
        else if (next_frame)
        begin
            shift_in   <= WORD_ZERO;
            rise_count <= 5'h0;
        end
        else if (rise && buf_ready)
        begin
            shift_in   <= {shift_in[WORD_BITS-2:0], din_lvl};
            rise_count <= word_done ? 5'h0 : rise_count + 5'h1;
        end
    end

    // Output shifter: MSB first, loaded at frame fall or on the word boundary
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shift_out <= WORD_ZERO;
            dout_out  <= 1'b0;
            din_out   <= 1'b0;
            tx_taken  <= 1'b0;
        end
        else
        begin
            tx_taken <= 1'b0;
            if (frame_fall)
            begin
                tx_taken <= 1'b1;
                if (!sclk_lvl)
                begin
                    // Clock already low: frame-sync itself shows the MSB, so drop it here
                    shift_out <= {tx_word[WORD_BITS-2:0], 1'b0};
                    dout_out  <= tx_word[WORD_BITS-1];
                    din_out   <= tx_word[WORD_BITS-1];
                end
                else
                    shift_out <= tx_word;
            end
            else if (word_done)
            begin
                shift_out <= tx_word;
                tx_taken  <= 1'b1;
            end
            else if (fall)
            begin
                shift_out <= {shift_out[WORD_BITS-2:0], 1'b0};
                dout_out  <= shift_out[WORD_BITS-1];
                din_out   <= shift_out[WORD_BITS-1];
            end
        end
    end

    // ***********************************************************
    // Received words and control bits
    // ***********************************************************
    rx_word_s in_word;
    logic     in_valid;
    assign in_word.data = {shift_in[WORD_BITS-2:0], din_lvl};
    assign in_word.cal  = cal_write;
    // Every complete word is offered; a full buffer stalls capture instead
    assign in_valid = word_done && buf_ready;

    word_buffer rx_buffer (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_valid  (in_valid),
        .in_ready  (buf_ready),
        .in_word   (in_word),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_word  (rx_word)
    );

    dir_state_e dir;
    logic [3:0] turn_count;

    // Mode and conversion start come only from written words or the pin
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            two_wire   <= 1'b0;
            conv_start <= 1'b0;
        end
        else
        begin
            conv_start <= 1'b0;
            if (in_valid && !(two_wire && dir == SEND))
            begin
                two_wire <= in_word.data[TWO_WIRE_BIT];
                if (in_word.data[CONV_START_BIT])
                    conv_start <= 1'b1;
            end
            if (conv_lvl && !next_conv)
                conv_start <= 1'b1;
        end
    end

    // ***********************************************************
    // Two-wire pin direction
    // ***********************************************************
    // Direction flips each sixteenth rising edge; calibration holds it
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dir        <= IDLE;
            turn_count <= 4'h0;
        end
        else
        begin
            case (dir)
                IDLE:
                    if (two_wire && active)
                        dir <= RECEIVE;
                RECEIVE:
                    if (word_done && !cal_write)
                        dir <= SEND;
                SEND:
                    if (word_done && !cal_read)
                    begin
                        dir        <= TURN;
                        turn_count <= TURNAROUND_CYCLES;
                    end
                TURN:
                    if (turn_count == 4'h1)
                        dir <= RECEIVE;
                    else
                        turn_count <= turn_count - 4'h1;
                default:
                    dir <= IDLE;
            endcase
            if (!two_wire)
                dir <= IDLE;
        end
    end

    // Pin enables; frame-sync high floats both data outputs
    assign dout_oe = !two_wire && !frame_lvl;
    assign din_oe  = two_wire && !frame_lvl && (dir == SEND);

    shared_float_a : assert property (@(posedge clock) disable iff (!reset_n)
        frame_lvl |-> !din_oe && !dout_oe) else $error("pin driven with frame high");
    reset_mode_a : assert property (@(posedge clock) disable iff (!reset_n)
        $rose(reset_n) |-> !two_wire) else $error("mode not three-wire");
    idle_clear_a : assert property (@(posedge clock) disable iff (!reset_n)
        next_frame |=> rise_count == 5'h0) else $error("count kept with frame high");
    no_capture_a : assert property (@(posedge clock) disable iff (!reset_n)
        frame_lvl && next_frame |=> $stable(shift_in)) else $error("capture while idle");
    turn_bound_a : assert property (@(posedge clock) disable iff (!reset_n)
        dir == TURN |-> ##[1:15] dir != TURN) else $error("turnaround too long");
    send_after_a : assert property (@(posedge clock) disable iff (!reset_n)
        dir == RECEIVE && word_done && !cal_write && two_wire |=> dir == SEND)
        else $error("no turn to output");
    cal_hold_a : assert property (@(posedge clock) disable iff (!reset_n)
        dir == SEND && cal_read && two_wire |=> dir == SEND) else $error("cal read released");
    dout_frame_a : assert property (@(posedge clock) disable iff (!reset_n)
        !two_wire && !frame_lvl |-> dout_oe) else $error("three-wire output off");
endmodule

/* File: shared/serial_port_pkg.sv */
// Package with constants and carrier types for the converter's serial host port
package serial_port_pkg;
    localparam int          WORD_BITS        = 16;
    localparam logic [4:0]  BIT_COUNT_FULL   = 5'h10;
    localparam logic [15:0] WORD_ZERO        = 16'h0000;
    // Control word fields seen by this port
    localparam int          TWO_WIRE_BIT     = 1;
    localparam int          CONV_START_BIT   = 0;
    // Clock and turnaround timing
    localparam int          CLOCK_PERIOD_NS  = 50;
    localparam int          TURNAROUND_NS    = 100;
    localparam int          TURNAROUND_CYCLES_RAW = TURNAROUND_NS / CLOCK_PERIOD_NS;
    localparam logic [3:0]  TURNAROUND_CYCLES =
        (TURNAROUND_CYCLES_RAW < 1) ? 4'h1 : TURNAROUND_CYCLES_RAW[3:0];
    localparam int          BUF_DEPTH        = 2;

    typedef logic [15:0] word_t;

    // Word plus calibration tag as it moves through the buffer
    typedef struct packed {
        word_t data;
        logic  cal;
    } rx_word_s;

    typedef enum logic [1:0] {
        IDLE    = 2'b00,
        RECEIVE = 2'b01,
        SEND    = 2'b11,
        TURN    = 2'b10
    } dir_state_e;
endpackage

/* File: core/word_buffer.sv */
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ns
module word_buffer
    import serial_port_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     reset_n,
    input  wire logic     in_valid,
    output logic          in_ready,
    input  wire rx_word_s in_word,
    output logic          out_valid,
    input  wire logic     out_ready,
    output rx_word_s      out_word
);
    rx_word_s   store [BUF_DEPTH];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] fill;

    assign in_ready  = (fill != 2'(BUF_DEPTH));
    assign out_valid = (fill != 2'h0);

    // Read data come straight from a register entry
    assign out_word = store[rd_ptr];

    // Storage write
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            store[0] <= '0;
            store[1] <= '0;
        end
        else if (in_valid && in_ready)
        begin
            store[wr_ptr] <= in_word;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fill   <= 2'h0;
        end
        else
        begin
            if (in_valid && in_ready)
                wr_ptr <= ~wr_ptr;
            if (out_valid && out_ready)
                rd_ptr <= ~rd_ptr;
            fill <= fill + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
        end
    end

    fill_bound_a : assert property (@(posedge clock) disable iff (!reset_n)
        fill <= 2'(BUF_DEPTH)) else $error("buffer overfilled");
endmodule

/* File: verification/host_master.sv */
// Serial master model that frames words and clocks the converter port
`timescale 1ns/1ns
module host_master
(
    input  wire logic clock,
    input  wire logic miso,
    input  wire logic oe,
    output logic      sclk,
    output logic      frame_n,
    output logic      mosi
);
    int   half    = 4;
    logic oe_last = 1'b0;

    // Gated clock rests high between frames
    initial
    begin
        sclk    = 1'b1;
        frame_n = 1'b1;
        mosi    = 1'b0;
    end

    // ************************************************
    // Framed word, MSB first, bits gives the clock count
    // ************************************************
    task automatic xfer(input logic [15:0] tx, input int bits, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge clock);
        frame_n = 1'b0;
        repeat (half) @(negedge clock);
        for (int i = 15; i > 15 - bits; i--)
        begin
            sclk = 1'b0;
            mosi = tx[i];
            repeat (half) @(negedge clock);
            sclk = 1'b1;
            // Sample late in the high phase, the port answers a few cycles after each fall
            repeat (half) @(negedge clock);
            rx[i] = miso;
        end
        // Never more than sixteen clocks inside one frame
        repeat (2 * half) @(negedge clock);
        oe_last = oe;
        frame_n = 1'b1;
        mosi    = ~mosi;
        repeat (half) @(negedge clock);
    endtask

    // Clock pulses with the frame held high
    task automatic stray(input int n);
        repeat (n)
        begin
            sclk = 1'b0;
            repeat (half) @(negedge clock);
            sclk = 1'b1;
            repeat (half) @(negedge clock);
        end
    endtask
endmodule

/* File: verification/adc_serial_port_two_three_wire_tb.sv */
// Self-checking bench for the converter's serial host port
`timescale 1ns/1ns
module adc_serial_port_two_three_wire_tb
    import serial_port_pkg::*;
;
    logic        clock;
    logic        reset_n;
    logic        sclk;
    logic        frame_n;
    logic        mosi;
    logic        din_in;
    logic        din_out;
    logic        din_oe;
    logic        dout_out;
    logic        dout_oe;
    logic        conversion_start_n;
    word_t       tx_word;
    logic        cal_read;
    logic        cal_write;
    logic        rx_valid;
    logic        rx_ready;
    rx_word_s    rx_word;
    logic        two_wire;
    logic        conv_start;
    logic [15:0] rd;
    int          errors      = 0;
    int          checks_done = 0;
    int          conv_count  = 0;
    int          take_count  = 0;
    logic        tx_taken;

    // Shared pin level: the port wins while it drives
    assign din_in = din_oe ? din_out : mosi;

    serial_port i_dut (.clock(clock), .reset_n(reset_n), .sclk(sclk), .frame_n(frame_n),
        .din_in(din_in), .din_out(din_out), .din_oe(din_oe), .dout_out(dout_out),
        .dout_oe(dout_oe), .conversion_start_n(conversion_start_n), .tx_word(tx_word),
        .cal_read(cal_read), .cal_write(cal_write), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_word(rx_word), .tx_taken(tx_taken), .two_wire(two_wire), .conv_start(conv_start));

    host_master i_host (.clock(clock), .miso(two_wire ? din_in : dout_out), .oe(din_oe),
        .sclk(sclk), .frame_n(frame_n), .mosi(mosi));

    // Clock and a hang limit
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial
    begin
        repeat (60000) @(posedge clock);
        errors++;
        stop_test();
    end

    // Pulses last one cycle; count them mid-cycle, away from the launching edge
    always @(negedge clock)
    begin
        if (conv_start === 1'b1)
            conv_count <= conv_count + 1;
        if (tx_taken === 1'b1)
            take_count <= take_count + 1;
    end

    // ************************************************
    // Compare, receive and closing tasks
    // ************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pop(input logic [15:0] exp, input logic cal = 1'b0);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 40)
        begin
            @(negedge clock);
            n++;
        end
        if (n == 40)
        begin
            errors++;
            $display("CHECK FAILED rx_valid expected 1 seen 0");
            stop_test();
        end
        else
        begin
            chk("rx word", exp, rx_word.data);
            chk("rx cal", {15'h0000, cal}, {15'h0000, rx_word.cal});
            rx_ready = 1'b1;
            @(negedge clock);
            rx_ready = 1'b0;
            @(negedge clock);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ************************************************
    // Main sequence
    // ************************************************
    initial
    begin
        reset_n            = 1'b0;
        conversion_start_n = 1'b1;
        tx_word            = 16'h2c5a;
        cal_read           = 1'b0;
        cal_write          = 1'b0;
        rx_ready           = 1'b0;
        repeat (12) @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        chk("two_wire", 16'h0000, {15'h0000, two_wire});
        chk("dout_oe", 16'h0000, {15'h0000, dout_oe});
        // Full duplex frame, MSB first on the first falling clock
        i_host.xfer(16'h1234, 16, rd);
        chk("read word", 16'h2c5a, rd);
        pop(16'h1234);
        chk("tx taken", 16'h0002, take_count[15:0]);
        // Receiver stalls across two frames, then a slow host
        tx_word = 16'h7e81;
        i_host.xfer(16'h5670, 16, rd);
        i_host.half = 8;
        i_host.xfer(16'h0001, 16, rd);
        i_host.half = 4;
        chk("slow read", 16'h7e81, rd);
        pop(16'h5670);
        pop(16'h0001);
        chk("soft start", 16'h0001, conv_count[15:0]);
        chk("mode kept", 16'h0000, {15'h0000, two_wire});
        // Pin start
        conversion_start_n = 1'b0;
        repeat (2) @(negedge clock);
        conversion_start_n = 1'b1;
        repeat (8) @(negedge clock);
        chk("pin start", 16'h0002, conv_count[15:0]);
        // Clocks with frame high capture nothing
        i_host.stray(6);
        chk("stray rx", 16'h0000, {15'h0000, rx_valid});
        // Aborted frame, then a word with the two-wire bit set enters two-wire mode
        i_host.xfer(16'hffff, 5, rd);
        i_host.xfer(16'h4002, 16, rd);
        pop(16'h4002);
        chk("two_wire set", 16'h0001, {15'h0000, two_wire});
        // Calibration write: the shared pin stays an input after the word
        cal_write = 1'b1;
        i_host.xfer(16'h0a02, 16, rd);
        chk("cal write in", 16'h0000, {15'h0000, i_host.oe_last});
        cal_write = 1'b0;
        pop(16'h0a02, 1'b1);
        // Two-wire write: the shared pin turns round after the sixteenth rise
        i_host.xfer(16'h0002, 16, rd);
        chk("pin out", 16'h0001, {15'h0000, i_host.oe_last});
        chk("pin float", 16'h0000, {15'h0000, din_oe});
        pop(16'h0002);
        // Calibration read: the shared pin stays an output after the word
        cal_read = 1'b1;
        tx_word  = 16'h1e3c;
        i_host.xfer(16'h0002, 16, rd);
        chk("cal read", 16'h1e3c, rd);
        chk("cal read out", 16'h0001, {15'h0000, i_host.oe_last});
        cal_read = 1'b0;
        // Two-wire read on the shared pin
        tx_word = 16'h3bd4;
        i_host.xfer(16'h0002, 16, rd);
        chk("shared read", 16'h3bd4, rd);
        chk("pin back in", 16'h0000, {15'h0000, i_host.oe_last});
        rx_ready = 1'b1;
        stop_test();
    end
endmodule
